// ---- include/addr_front_pkg.sv ----
// Functional notes
// - Only the first byte after a start condition is compared as the slave address.
// - Addressing is 7-bit, so one address byte opens each transaction and no extended byte is expected.
// - Bits 7 to 1 of the address byte hold the address and bit 0 the direction, 1 for read and 0 for write.
// - With the preset address 0x18 the device answers address bytes 0x30 for write and 0x31 for read.
// - The address comes from non-volatile storage, a programmed value on a programmed part or else a factory preset.
// - The second byte of a write transaction is loaded as the register pointer.
// - With the override option on, the address LSB is replaced by the address select pin level.
package addr_front_pkg;
  localparam logic [6:0] PRESET_ADDR = 7'h18;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BITS_AT_START = 3'h3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_PTR = 3'b010,
    ST_PTR_ACK = 3'b110,
    ST_DATA = 3'b111,
    ST_IGNORE = 3'b101
  } link_state_t;

  typedef struct packed {
    logic [6:0] nvm_addr;
    logic nvm_programmed;
    logic override_en;
  } addr_cfg_t;

  typedef struct packed {
    logic [7:0] pointer;
    logic read_req;
  } access_t;
endpackage : addr_front_pkg

// ---- logic/slave_address_front_end.sv ----
`timescale 1ns/10ps
`default_nettype none
module slave_address_front_end (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic address_select_pin,
  input wire addr_front_pkg::addr_cfg_t cfg,
  output addr_front_pkg::access_t access,
  output logic access_strobe
);
  import addr_front_pkg::*;

  // Start/stop detect needs the raw SDA seen on the system clock
  logic [1:0] sda_sync;
  logic [1:0] scl_sync;
  logic sda_d;
  logic scl_d;
  logic [1:0] next_sda_sync;
  logic [1:0] next_scl_sync;
  logic next_sda_d;
  logic next_scl_d;
  logic start_seen;
  logic stop_seen;

  always_comb begin
    next_sda_sync = {sda_sync[0], sda_in};
    next_scl_sync = {scl_sync[0], scl_clk};
    next_sda_d = sda_sync[1];
    next_scl_d = scl_sync[1];
    start_seen = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
    stop_seen = scl_sync[1] && scl_d && !sda_d && sda_sync[1];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sda_sync <= 2'b11;
      scl_sync <= 2'b11;
      sda_d <= 1'b1;
      scl_d <= 1'b1;
    end else if (ce) begin
      sda_sync <= next_sda_sync;
      scl_sync <= next_scl_sync;
      sda_d <= next_sda_d;
      scl_d <= next_scl_d;
    end
  end

  // Effective address, caught in the system domain
  function automatic logic [6:0] eff_addr(input addr_cfg_t c, input logic sel);
    logic [6:0] a;
    a = c.nvm_programmed ? c.nvm_addr : PRESET_ADDR;
    if (c.override_en) begin
      a[0] = sel;
    end
    return a;
  endfunction

  logic [1:0] sel_sync;
  logic [6:0] my_addr;
  logic [1:0] next_sel_sync;
  logic [6:0] next_my_addr;

  always_comb begin
    next_sel_sync = {sel_sync[0], address_select_pin};
    next_my_addr = eff_addr(cfg, sel_sync[1]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_sync <= 2'b00;
      my_addr <= PRESET_ADDR;
    end else if (ce) begin
      sel_sync <= next_sel_sync;
      my_addr <= next_my_addr;
    end
  end

  // Start/stop events cross to the link side as toggles
  logic start_tgl;
  logic stop_tgl;
  logic next_start_tgl;
  logic next_stop_tgl;

  always_comb begin
    next_start_tgl = start_tgl ^ start_seen;
    next_stop_tgl = stop_tgl ^ stop_seen;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      start_tgl <= 1'b0;
      stop_tgl <= 1'b0;
    end else if (ce) begin
      start_tgl <= next_start_tgl;
      stop_tgl <= next_stop_tgl;
    end
  end

  // Link domain, clocked by SCL; address is static during a frame

  // Frame sequencing
  link_state_t state;
  link_state_t next_state;

  // Bit shifter and bit count within the byte
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [2:0] bitcnt;
  logic [2:0] next_bitcnt;

  // Last start and stop toggles already acted on
  logic start_ack;
  logic stop_ack;
  logic next_start_ack;
  logic next_stop_ack;

  // Register pointer and direction of the frame
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic rd;
  logic next_rd;

  // ACK request, launched on the falling SCL edge
  logic ack_drive;
  logic next_ack_drive;
  logic next_ack_drive_q;

  // Access event toward the system clock
  logic ev_tgl;
  logic next_ev_tgl;

  // Start and stop toggles seen on SCL rising edges
  logic [1:0] st_sync;
  logic [1:0] sp_sync;

  // Link logic shares the system reset
  logic link_rst;

  assign link_rst = rst;

  always_comb begin
    next_state = state;
    next_shreg = {shreg[6:0], sda_in};
    next_bitcnt = bitcnt + 3'h1;
    next_start_ack = st_sync[1];
    next_stop_ack = sp_sync[1];
    next_ptr = ptr;
    next_rd = rd;
    next_ev_tgl = ev_tgl;
    next_ack_drive = 1'b0;
    if (st_sync[1] != start_ack) begin
      // The start toggle needs two SCL rises to cross.
      // The shifter runs on anyway, so the three bits taken
      // up to the acting rise are already in it; count them here.
      // first byte after start is address
      next_state = ST_ADDR;
      next_bitcnt = BITS_AT_START;
    end else if (sp_sync[1] != stop_ack) begin
      next_state = ST_IDLE;
    end else begin
      case (state)
        ST_ADDR: begin
          if (bitcnt == BIT_LAST) begin
            // bits 7..1 address, bit 0 direction
            if (next_shreg[7:1] == my_addr) begin
              next_state = ST_ADDR_ACK;
              next_rd = next_shreg[0];
              next_ack_drive = 1'b1;
            end else begin
              next_state = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          next_bitcnt = 3'h0;
          if (rd) begin
            next_state = ST_DATA;
            next_ev_tgl = ~ev_tgl;
          end else begin
            next_state = ST_PTR;
          end
        end
        ST_PTR: begin
          if (bitcnt == BIT_LAST) begin
            next_ptr = next_shreg;
            next_state = ST_PTR_ACK;
            next_ack_drive = 1'b1;
          end
        end
        ST_PTR_ACK: begin
          next_state = ST_DATA;
          next_ev_tgl = ~ev_tgl;
        end
        default: begin
          next_bitcnt = bitcnt;
        end
      endcase
    end
  end

  always_ff @(posedge scl_clk) begin
    if (link_rst) begin
      state <= ST_IDLE;
      shreg <= BYTE_ZERO;
      bitcnt <= 3'h0;
      start_ack <= 1'b0;
      stop_ack <= 1'b0;
      st_sync <= 2'b00;
      sp_sync <= 2'b00;
      ptr <= PTR_RESET;
      rd <= 1'b0;
      ev_tgl <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      start_ack <= next_start_ack;
      stop_ack <= next_stop_ack;
      st_sync <= {st_sync[0], start_tgl};
      sp_sync <= {sp_sync[0], stop_tgl};
      ptr <= next_ptr;
      rd <= next_rd;
      ev_tgl <= next_ev_tgl;
    end
  end

  // ACK driven from SCL falling edge so data is stable while high
  always_ff @(negedge scl_clk) begin
    if (link_rst) begin
      ack_drive <= 1'b0;
    end else begin
      ack_drive <= next_ack_drive_q;
    end
  end

  // Holds the ACK request from the rising to the falling edge
  always_ff @(posedge scl_clk) begin
    if (link_rst) begin
      next_ack_drive_q <= 1'b0;
    end else begin
      next_ack_drive_q <= next_ack_drive;
    end
  end

  // Access event back to system clock; pointer stable after toggle
  logic [2:0] ev_sync;
  access_t next_access;
  logic next_access_strobe;
  logic out_oe_n;
  logic next_out_oe_n;

  always_comb begin
    next_access = access;
    next_access_strobe = ev_sync[2] != ev_sync[1];
    if (next_access_strobe) begin
      next_access.pointer = ptr;
      next_access.read_req = rd;
    end
    next_out_oe_n = ~ack_drive;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_sync <= 3'b000;
      access <= '0;
      access_strobe <= 1'b0;
      out_oe_n <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (ce) begin
      ev_sync <= {ev_sync[1:0], ev_tgl};
      access <= next_access;
      access_strobe <= next_access_strobe;
      out_oe_n <= next_out_oe_n;
      sda_out <= 1'b0;
      sda_oe_n <= out_oe_n;
    end
  end
endmodule : slave_address_front_end
`default_nettype wire

// ---- sim/front_end_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module front_end_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire addr_front_pkg::access_t access,
  input wire logic access_strobe
);
  import addr_front_pkg::*;
  logic [4:0] since_ack;
  logic [4:0] next_since_ack;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_comb begin
    next_since_ack = since_ack + ((since_ack == 5'h1f) ? 5'h0 : 5'h1);
    if (!sda_oe_n) begin
      next_since_ack = 5'h0;
    end
  end
  always_ff @(posedge clk) begin
    since_ack <= rst ? 5'h1f : next_since_ack;
  end
  AST_NO_DRIVE_HIGH: assert property (sda_out == 1'b0) else $error("sda driven high");
  AST_ACK_MIN: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*3]) else $error("ack too short");
  AST_ACK_REL: assert property ($fell(sda_oe_n) |-> ##[1:20] sda_oe_n) else $error("ack not released");
  AST_ACK_GAP: assert property ($rose(sda_oe_n) |=> sda_oe_n [*8]) else $error("ack too soon");
  AST_STB_ACK: assert property (access_strobe |-> since_ack < 5'h10) else $error("strobe without ack");
  AST_STB_GAP: assert property (access_strobe |=> !access_strobe [*8]) else $error("strobe repeat");
  AST_ACC_HOLD: assert property ($changed(access) |-> access_strobe || $past(access_strobe))
    else $error("access moved alone");
  AST_READ_PTR: assert property ($rose(access.read_req) |-> $stable(access.pointer)) else $error("read moved ptr");
  cover property (access_strobe && access.read_req);
  cover property (access_strobe && !access.read_req);
  cover property ($fell(sda_oe_n));
endmodule : front_end_sva
bind slave_address_front_end front_end_sva u_sva (.clk(clk), .rst(rst), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .access(access), .access_strobe(access_strobe));
`default_nettype wire

// ---- sim/host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_model (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input logic b, output logic seen);
    scl = 1'b0;
    #20 sda_drv = b;
    #20 scl = 1'b1;
    seen = sda;
    #40;
  endtask : tick
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) tick(v[i], s);
    tick(1'b1, s);
    ack = !s;
  endtask : put_byte
  task automatic frame(input logic [7:0] a, input logic [7:0] p, output logic ka, output logic kp);
    sda_drv = 1'b0;
    #200;
    put_byte(a, ka);
    kp = 1'b0;
    if (!a[0]) put_byte(p, kp);
    scl = 1'b0;
    #20 sda_drv = 1'b0;
    #20 scl = 1'b1;
    #100 sda_drv = 1'b1;
    #300;
  endtask : frame
endmodule : host_model
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  import addr_front_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pin = 1'b0;
  logic stb, sda_out, sda_oe_n, scl, sda_drv;
  addr_cfg_t cfg = '0;
  access_t acc;
  access_t exp_acc = '0;
  wire logic sda;
  int fail_count = 0;
  int cmp_count = 0;
  int n_stb = 0;
  assign sda = sda_drv & (sda_oe_n | sda_out);
  always #5 clk = ~clk;
  always @(negedge clk) if (stb) n_stb++;
  slave_address_front_end u_slave_address_front_end (.clk(clk), .rst(rst), .ce(1'b1), .scl_clk(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_pin(pin), .cfg(cfg),
    .access(acc), .access_strobe(stb));
  host_model u_host_model (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task end_of_test;
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  function automatic logic [6:0] eff_addr(addr_cfg_t c, logic p);
    logic [6:0] e;
    e = c.nvm_programmed ? c.nvm_addr : PRESET_ADDR;
    if (c.override_en) e[0] = p;
    return e;
  endfunction : eff_addr
  task automatic run(input logic [7:0] a, input logic [7:0] p);
    logic ka, kp, hit;
    int n0;
    hit = (a[7:1] == eff_addr(cfg, pin));
    repeat (4) @(negedge clk);
    n0 = n_stb;
    u_host_model.frame(a, p, ka, kp);
    repeat (20) @(negedge clk);
    if (hit) exp_acc = '{pointer: a[0] ? exp_acc.pointer : p, read_req: a[0]};
    check("addr ack", 9'(ka), 9'(hit));
    if (!a[0]) check("ptr ack", 9'(kp), 9'(hit));
    check("strobes", 9'(n_stb - n0), 9'(hit));
    check("access", acc, exp_acc);
  endtask : run
  initial begin
    logic [7:0] a;
    void'($urandom(83463));
    u_host_model.tick(1'b1, a[0]);
    repeat (2) @(negedge clk);
    rst = 1'b0;
    run(8'h30, 8'h5a);
    run(8'h31, 8'h00);
    run(8'h32, 8'hff);
    cfg.override_en = 1'b1;
    pin = 1'b1;
    run(8'h33, 8'ha5);
    run(8'h30, 8'h11);
    cfg = '{nvm_addr: 7'h7f, nvm_programmed: 1'b1, override_en: 1'b0};
    run(8'hfe, 8'h01);
    for (int i = 0; i < 30; i++) begin
      cfg = addr_cfg_t'($urandom);
      pin = 1'($urandom);
      a = ($urandom % 2) ? {eff_addr(cfg, pin), 1'($urandom)} : 8'($urandom);
      run(a, 8'($urandom));
    end
    end_of_test();
  end
endmodule : tb
`default_nettype wire
